// File: rtl/isa_axil_slave.sv
// Purpose: axi4-lite slave turning handshakes into register strobes
// Assumes: one write and one read outstanding at most
// Notes:   read answers one cycle, write answers two cycles after the last address or data is taken
`timescale 1ns/1ps
module isa_axil_slave (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write channels
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // read channels
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // register side
    isa_bus_if.slave         bus
);
    logic       aw_reg, aw_next, w_reg, w_next;
    logic [7:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
    logic       wstrb_reg, wstrb_next;
    logic       bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       aw_take, w_take, ar_take, do_wr;

    always_comb begin
        aw_take     = s_axi_awvalid & ~aw_reg & ~bvalid_reg;
        w_take      = s_axi_wvalid & ~w_reg & ~bvalid_reg;
        ar_take     = s_axi_arvalid & ~rvalid_reg;
        do_wr       = aw_reg & w_reg & ~bvalid_reg;
        aw_next     = (aw_reg | aw_take) & ~do_wr;
        w_next      = (w_reg | w_take) & ~do_wr;
        awaddr_next = aw_take ? s_axi_awaddr : awaddr_reg;
        wdata_next  = w_take ? s_axi_wdata[7:0] : wdata_reg;
        wstrb_next  = w_take ? s_axi_wstrb[0] : wstrb_reg;
        bvalid_next = do_wr | (bvalid_reg & ~s_axi_bready);
        bresp_next  = do_wr ? (bus.wr_hit ? isa_pkg::RESP_OKAY
                                          : isa_pkg::RESP_SLVERR) : bresp_reg;
        rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
        rdata_next  = ar_take ? bus.rdata : rdata_reg;
        rresp_next  = ar_take ? (bus.rd_hit ? isa_pkg::RESP_OKAY
                                            : isa_pkg::RESP_SLVERR)
                              : rresp_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_reg     <= 1'b0;
            w_reg      <= 1'b0;
            awaddr_reg <= isa_pkg::RST_BYTE;
            wdata_reg  <= isa_pkg::RST_BYTE;
            wstrb_reg  <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= isa_pkg::RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg  <= isa_pkg::RST_BYTE;
            rresp_reg  <= isa_pkg::RESP_OKAY;
        end else begin
            aw_reg     <= aw_next;
            w_reg      <= w_next;
            awaddr_reg <= awaddr_next;
            wdata_reg  <= wdata_next;
            wstrb_reg  <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg  <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    assign s_axi_awready = ~aw_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_reg & ~bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = {24'h000000, rdata_reg};
    assign bus.wr_en     = do_wr;
    assign bus.wr_addr   = awaddr_reg;
    assign bus.wdata     = wdata_reg;
    assign bus.wstrb0    = wstrb_reg;
    assign bus.rd_en     = ar_take;
    assign bus.rd_addr   = s_axi_araddr;
endmodule

// File: rtl/isa_if.sv
// Purpose: carriers between the block's modules
// Assumes: all signals on aclk
// Notes:   bus carrier holds one-cycle strobes
`timescale 1ns/1ps
interface isa_bus_if;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wdata;
    logic       wstrb0;
    logic       wr_hit;
    logic       rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rdata;
    logic       rd_hit;
    modport slave (output wr_en, wr_addr, wdata, wstrb0, rd_en, rd_addr,
                   input wr_hit, rdata, rd_hit);
    modport regs  (input wr_en, wr_addr, wdata, wstrb0, rd_en, rd_addr,
                   output wr_hit, rdata, rd_hit);
endinterface

interface isa_link_if;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic start_det;
    logic stop_det;
    modport src (output scl_rise, scl_fall, sda_lvl, start_det, stop_det);
    modport dst (input scl_rise, scl_fall, sda_lvl, start_det, stop_det);
endinterface

// File: rtl/isa_pin_sync.sv
// Purpose: synchronise scl and sda, find edges, start and stop
// Assumes: scl slower than a few aclk periods
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module isa_pin_sync (
    // clock and reset
    input  wire logic   aclk,
    input  wire logic   aresetn,
    // pins
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    // events
    isa_link_if.src     link
);
    logic [1:0] scl_s1_reg, scl_s1_next;
    logic [1:0] s2_reg, s2_next;
    logic [1:0] s3_reg, s3_next;

    always_comb begin
        scl_s1_next = {scl_i, sda_i};
        s2_next     = scl_s1_reg;
        s3_next     = s2_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_s1_reg <= 2'h3;
            s2_reg     <= 2'h3;
            s3_reg     <= 2'h3;
        end else begin
            scl_s1_reg <= scl_s1_next;
            s2_reg     <= s2_next;
            s3_reg     <= s3_next;
        end
    end

    // bit 1 is scl, bit 0 is sda
    assign link.scl_rise  = s2_reg[1] & ~s3_reg[1];
    assign link.scl_fall  = ~s2_reg[1] & s3_reg[1];
    assign link.sda_lvl   = s2_reg[0];
    assign link.start_det = s2_reg[1] & s3_reg[1] & ~s2_reg[0] & s3_reg[0];
    assign link.stop_det  = s2_reg[1] & s3_reg[1] & s2_reg[0] & ~s3_reg[0];
endmodule

// File: rtl/isa_pkg.sv
// Purpose: shared constants for the bus status and slave address block
// Assumes: axi4-lite data 32 bits, registers in the low byte
// Notes:   byte addresses are word aligned
package isa_pkg;
    localparam int ADDR_W = 8;
    // register byte addresses
    localparam logic [7:0] OFF_STATUS   = 8'h00;
    localparam logic [7:0] OFF_SLV_ADDR = 8'h04;
    localparam logic [7:0] OFF_TX_BUF   = 8'h08;
    localparam logic [7:0] OFF_RX_BUF   = 8'h0c;
    localparam logic [7:0] OFF_CTRL     = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    // status flag positions
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_TX_END   = 6;
    localparam int BIT_RX_FULL  = 5;
    // slave address register fields
    localparam int BIT_FMT_SEL  = 0;
    // control register fields
    localparam int BIT_TRS      = 0;
    localparam int BIT_TX_MODE  = 1;
    localparam int BIT_ADDRSD   = 2;
    // irq event positions
    localparam int EV_TX_EMPTY  = 0;
    localparam int EV_TX_END    = 1;
    localparam int EV_RX_FULL   = 2;
    localparam int EV_ADDR_HIT  = 3;
    // reset values
    localparam logic [7:0] RST_SLV_ADDR = 8'h00;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [3:0] RST_IRQ      = 4'h0;
    // bit counter marks and bus response codes
    localparam logic [3:0] CNT_LAST_BIT = 4'h7;
    localparam logic [3:0] CNT_ACK      = 4'h8;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10
    } isa_phase_e;

    // mapped, aligned register address
    function automatic logic addr_hit(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFF_IRQ_MASK);
    endfunction
endpackage

// File: rtl/isa_top.sv
// Purpose: status flags, slave address match and format select
// Assumes: scl and sda come from pins, asynchronous to aclk
// Notes:   slave only, no clock stretching; empty buffer sends ones
//
// What this block does
// RULE1: tx empty flag sets when buffer byte moves into shift register.
// RULE2: tx empty also sets on transmit select, start, slave rx-to-tx.
// RULE3: tx empty clears on write 0 after read 1, or buffer write.
// RULE4: i2c format: tx end sets at ninth scl rise while tx empty.
// RULE5: synchronous format: tx end sets after last frame bit shifted.
// RULE6: tx end clears on write 0 after read 1, or buffer write.
// RULE7: rx full sets when received byte moves into rx buffer.
// RULE8: rx full clears on write 0 after read 1, or rx buffer read.
// RULE9: i2c slave answers when first byte's upper seven bits match.
// RULE10: software gives each slave on the bus a unique address.
// RULE11: format select bit 0: 0 i2c, 1 synchronous; resets 0.
// RULE12: writing 1 to a status flag leaves it unchanged.
`timescale 1ns/1ps
module isa_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // register bus
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // two-wire link
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // interrupt
    output logic             irq
);
    isa_bus_if  bus ();
    isa_link_if link ();

    isa_axil_slave u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .bus           (bus.slave)
    );

    isa_pin_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .link    (link.src)
    );

    // state
    logic [2:0]        flags_reg, flags_next;   // tx empty, tx end, rx full
    logic [2:0]        seen_reg, seen_next;
    logic [7:0]        sar_reg, sar_next;
    logic              trs_reg, trs_next;
    logic [7:0]        tx_buf_reg, tx_buf_next;
    logic              tx_valid_reg, tx_valid_next;
    logic [7:0]        rx_buf_reg, rx_buf_next;
    logic [7:0]        shift_reg, shift_next;
    logic [3:0]        cnt_reg, cnt_next;
    isa_pkg::isa_phase_e phase_reg, phase_next;
    logic              tx_mode_reg, tx_mode_next;
    logic              ack_due_reg, ack_due_next;
    logic              sda_oe_reg, sda_oe_next;
    logic [3:0]        irq_stat_reg, irq_stat_next;
    logic [3:0]        irq_mask_reg, irq_mask_next;
    logic              irq_reg, irq_next;

    // decoded strobes and events
    logic       fs, wr_ok, wr_status, wr_tx, rd_status, rd_rx, rd_irq;
    logic [7:0] rx_byte, status_val;
    logic [2:0] set_ev, clr_ev, trs_set;
    logic       addr_ev, tx_active, load_ok;

    assign fs         = sar_reg[isa_pkg::BIT_FMT_SEL];      // RULE11
    assign wr_ok      = bus.wr_en & bus.wstrb0 & bus.wr_hit;
    assign wr_status  = wr_ok & (bus.wr_addr == isa_pkg::OFF_STATUS);
    assign wr_tx      = wr_ok & (bus.wr_addr == isa_pkg::OFF_TX_BUF);
    assign rd_status  = bus.rd_en & (bus.rd_addr == isa_pkg::OFF_STATUS);
    assign rd_rx      = bus.rd_en & (bus.rd_addr == isa_pkg::OFF_RX_BUF);
    assign rd_irq     = bus.rd_en & (bus.rd_addr == isa_pkg::OFF_IRQ_STAT);
    assign rx_byte    = {shift_reg[6:0], link.sda_lvl};
    assign status_val = {flags_reg, 5'h00};
    assign tx_active  = fs ? trs_reg
                           : (phase_reg == isa_pkg::PH_DATA) & tx_mode_reg;
    assign load_ok    = link.scl_fall & (cnt_reg == 4'h0) & tx_active;

    assign bus.wr_hit = isa_pkg::addr_hit(bus.wr_addr);
    assign bus.rd_hit = isa_pkg::addr_hit(bus.rd_addr);

    always_comb begin
        unique case (bus.rd_addr)
            isa_pkg::OFF_STATUS:   bus.rdata = status_val;
            isa_pkg::OFF_SLV_ADDR: bus.rdata = sar_reg;
            isa_pkg::OFF_RX_BUF:   bus.rdata = rx_buf_reg;
            isa_pkg::OFF_CTRL:     bus.rdata = {5'h00,
                                       phase_reg == isa_pkg::PH_DATA,
                                       tx_mode_reg, trs_reg};
            isa_pkg::OFF_IRQ_STAT: bus.rdata = {4'h0, irq_stat_reg};
            isa_pkg::OFF_IRQ_MASK: bus.rdata = {4'h0, irq_mask_reg};
            default:               bus.rdata = isa_pkg::RST_BYTE;
        endcase
    end

    // link engine
    always_comb begin
        shift_next   = shift_reg;
        cnt_next     = cnt_reg;
        phase_next   = phase_reg;
        tx_mode_next = tx_mode_reg;
        ack_due_next = ack_due_reg;
        sda_oe_next  = sda_oe_reg;
        rx_buf_next  = rx_buf_reg;
        tx_valid_next = tx_valid_reg;
        set_ev       = 3'h0;
        addr_ev      = 1'b0;
        if (!fs && link.start_det) begin
            phase_next   = isa_pkg::PH_ADDR;
            cnt_next     = 4'h0;
            tx_mode_next = 1'b0;
            ack_due_next = 1'b0;
            sda_oe_next  = 1'b0;
            set_ev[2]    = 1'b1;                            // RULE2
        end else if (!fs && link.stop_det) begin
            phase_next   = isa_pkg::PH_IDLE;
            cnt_next     = 4'h0;
            tx_mode_next = 1'b0;
            sda_oe_next  = 1'b0;
        end else if (link.scl_rise && (fs || phase_reg != isa_pkg::PH_IDLE))
        begin
            shift_next = rx_byte;
            cnt_next   = cnt_reg + 4'h1;
            if (cnt_reg == isa_pkg::CNT_LAST_BIT) begin
                if (fs) begin
                    cnt_next    = 4'h0;
                    rx_buf_next = rx_byte;
                    set_ev[0]   = 1'b1;                     // RULE7
                    set_ev[1]   = trs_reg;                  // RULE5
                end else if (phase_reg == isa_pkg::PH_ADDR) begin
                    if (rx_byte[7:1] == sar_reg[7:1]) begin // RULE9
                        phase_next   = isa_pkg::PH_DATA;
                        tx_mode_next = rx_byte[0];
                        ack_due_next = 1'b1;
                        addr_ev      = 1'b1;
                        set_ev[2]    = rx_byte[0];          // RULE2
                    end else begin
                        phase_next   = isa_pkg::PH_IDLE;
                    end
                end else begin
                    ack_due_next = ~tx_mode_reg;
                    if (!tx_mode_reg) begin
                        rx_buf_next = rx_byte;
                        set_ev[0]   = 1'b1;                 // RULE7
                    end
                end
            end else if (cnt_reg == isa_pkg::CNT_ACK) begin
                cnt_next     = 4'h0;
                ack_due_next = 1'b0;
                set_ev[1]    = flags_reg[2];                // RULE4
                if (tx_mode_reg && link.sda_lvl && !ack_due_reg)
                    phase_next = isa_pkg::PH_IDLE;
            end
        end else if (link.scl_fall) begin
            if (load_ok) begin
                if (tx_valid_reg) begin
                    shift_next    = tx_buf_reg;
                    tx_valid_next = 1'b0;
                    set_ev[2]     = 1'b1;                   // RULE1
                    sda_oe_next   = ~tx_buf_reg[7];
                end else begin
                    shift_next    = 8'hff;
                    sda_oe_next   = 1'b0;
                end
            end else if (!fs && cnt_reg == isa_pkg::CNT_ACK) begin
                sda_oe_next = ack_due_reg;
            end else begin
                sda_oe_next = tx_active & ~shift_reg[7];
            end
        end
        if (wr_tx)
            tx_valid_next = 1'b1;
    end

    // software strobes, flag set and clear
    always_comb begin
        sar_next      = sar_reg;
        trs_next      = trs_reg;
        tx_buf_next   = tx_buf_reg;
        irq_mask_next = irq_mask_reg;
        clr_ev        = 3'h0;
        if (wr_ok && bus.wr_addr == isa_pkg::OFF_SLV_ADDR)
            sar_next = bus.wdata;                           // RULE10
        if (wr_ok && bus.wr_addr == isa_pkg::OFF_CTRL)
            trs_next = bus.wdata[isa_pkg::BIT_TRS];
        if (wr_ok && bus.wr_addr == isa_pkg::OFF_IRQ_MASK)
            irq_mask_next = bus.wdata[3:0];
        if (wr_tx)
            tx_buf_next = bus.wdata;
        // a written 1 does nothing
        if (wr_status)
            clr_ev = ~bus.wdata[7:5] & seen_reg; // RULE3 RULE6 RULE8 RULE12
        if (wr_tx)
            clr_ev[2:1] = 2'h3;                             // RULE3 RULE6
        if (rd_rx)
            clr_ev[0] = 1'b1;                               // RULE8
        flags_next = (flags_reg & ~clr_ev) | set_ev | trs_set;
        seen_next  = (rd_status ? flags_reg : seen_reg) & flags_next;
        irq_stat_next = (rd_irq ? 4'h0 : irq_stat_reg)
                      | {addr_ev, set_ev[0], set_ev[1] | trs_set[1],
                         set_ev[2] | trs_set[2]};
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    assign trs_set = {wr_ok && bus.wr_addr == isa_pkg::OFF_CTRL
                      && bus.wdata[isa_pkg::BIT_TRS] && !trs_reg,
                      2'h0};                                // RULE2

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg    <= 3'h0;
            seen_reg     <= 3'h0;
            sar_reg      <= isa_pkg::RST_SLV_ADDR;          // RULE11
            trs_reg      <= 1'b0;
            tx_buf_reg   <= isa_pkg::RST_BYTE;
            tx_valid_reg <= 1'b0;
            rx_buf_reg   <= isa_pkg::RST_BYTE;
            shift_reg    <= isa_pkg::RST_BYTE;
            cnt_reg      <= 4'h0;
            phase_reg    <= isa_pkg::PH_IDLE;
            tx_mode_reg  <= 1'b0;
            ack_due_reg  <= 1'b0;
            sda_oe_reg   <= 1'b0;
            irq_stat_reg <= isa_pkg::RST_IRQ;
            irq_mask_reg <= isa_pkg::RST_IRQ;
            irq_reg      <= 1'b0;
        end else begin
            flags_reg    <= flags_next;
            seen_reg     <= seen_next;
            sar_reg      <= sar_next;
            trs_reg      <= trs_next;
            tx_buf_reg   <= tx_buf_next;
            tx_valid_reg <= tx_valid_next;
            rx_buf_reg   <= rx_buf_next;
            shift_reg    <= shift_next;
            cnt_reg      <= cnt_next;
            phase_reg    <= phase_next;
            tx_mode_reg  <= tx_mode_next;
            ack_due_reg  <= ack_due_next;
            sda_oe_reg   <= sda_oe_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg      <= irq_next;
        end
    end

    // open drain: only ever pulls low
    assign sda_o  = 1'b0;
    assign sda_oe = sda_oe_reg;
    assign irq    = irq_reg;
endmodule

// File: test/isa_assertions.sv
// Purpose: bus handshake checks at the top ports
// Assumes: one aclk domain
// Notes:   bound from the bench top
`timescale 1ns/1ps
module isa_assertions (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // watched ports
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        sda_o
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sda_zero_a: assert property (sda_o == 1'b0)
        else $error("sda output not zero");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    r_late_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    b_late_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("b late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar ready during r");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready) else $error("aw ready during b");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule

// File: test/isa_master_model.sv
// Purpose: two-wire bus master, scl period 400 ns
// Assumes: sda pulled up, sda_rel high releases it
// Notes:   scl stands high between frames
`timescale 1ns/1ps
module isa_master_model (
    // link wires
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic down();
        scl = 1'b0;
        #100;
    endtask
    task automatic up(input logic b, output logic r);
        sda_rel = b;
        #100 scl = 1'b1;
        #100 r = sda;
        #100;
    endtask
    task automatic start();
        #7 sda_rel = 1'b0;
        #200;
    endtask
    task automatic stop();
        down();
        sda_rel = 1'b0;
        #100 scl = 1'b1;
        #100 sda_rel = 1'b1;
        #100;
    endtask
    task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
        #7;
        for (int i = 7; i >= 0; i--) begin
            down();
            up(d[i], q[i]);
        end
    endtask
    task automatic ack9(output logic a);
        down();
        up(1'b1, a);
    endtask
endmodule

// File: test/test_i2c_status_and_slave_address.sv
// Purpose: register and link tests of the status and address block
// Assumes: link idle during register accesses
// Notes:   handshakes sampled at the falling edge before each rise
`timescale 1ns/1ps
module test_i2c_status_and_slave_address;
    logic        aclk = 1'b0, aresetn = 1'b0, sda_rel, sda_i, scl_i, ack;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, q;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sda_o, sda_oe, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          bad_count = 0, comparisons = 0, cycles = 0;
    assign sda_i = sda_rel & ~sda_oe;
    always #25 aclk = ~aclk;
    isa_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_i, .sda_i, .sda_o,
        .sda_oe, .irq);
    isa_master_model m (.scl(scl_i), .sda_rel, .sda(sda_i));
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] msk, input logic [9:0] e);
        logic t_aw, t_w, t_ar, fin;
        logic [9:0] got;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        do begin
            @(negedge aclk);
            t_aw = s_axi_awready;
            t_w = s_axi_wready;
            t_ar = s_axi_arready;
            fin = s_axi_bvalid | s_axi_rvalid;
            got = wr ? {s_axi_bresp, 8'h00}
                     : {s_axi_rresp, s_axi_rdata[7:0] & msk};
            @(posedge aclk);
            if (t_aw) s_axi_awvalid <= 1'b0;
            if (t_w) s_axi_wvalid <= 1'b0;
            if (t_ar) s_axi_arvalid <= 1'b0;
        end while (!fin);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        check(got, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 8'h00, {isa_pkg::RESP_OKAY, 8'h00});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] msk,
                      input logic [7:0] e);
        acc(1'b0, a, 8'h00, msk, {isa_pkg::RESP_OKAY, e});
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(isa_pkg::OFF_SLV_ADDR, 8'hff, 8'h00);
        rd(isa_pkg::OFF_STATUS, 8'he0, 8'h00);
        acc(1'b0, 8'h1c, 8'h00, 8'h00, {isa_pkg::RESP_SLVERR, 8'h00});
        wr(isa_pkg::OFF_IRQ_MASK, 8'h04);
        wr(isa_pkg::OFF_SLV_ADDR, 8'h54);
        rd(isa_pkg::OFF_SLV_ADDR, 8'hff, 8'h54);
        m.start();
        m.byte_x(8'h20, q);
        m.ack9(ack);
        check(10'(ack), 10'h1);
        m.stop();
        m.start();
        m.byte_x(8'h54, q);
        m.ack9(ack);
        check(10'(ack), 10'h0);
        m.byte_x(8'ha5, q);
        m.ack9(ack);
        m.stop();
        wr(isa_pkg::OFF_STATUS, 8'hff);
        rd(isa_pkg::OFF_STATUS, 8'he0, 8'he0);
        @(negedge aclk);
        check(10'(irq), 10'h1);
        wr(isa_pkg::OFF_STATUS, 8'h00);
        rd(isa_pkg::OFF_STATUS, 8'h20, 8'h00);
        rd(isa_pkg::OFF_RX_BUF, 8'hff, 8'ha5);
        rd(isa_pkg::OFF_IRQ_STAT, 8'h04, 8'h04);
        repeat (2) @(negedge aclk);
        check(10'(irq), 10'h0);
        m.start();
        m.byte_x(8'h55, q);
        m.ack9(ack);
        check(10'(ack), 10'h0);
        rd(isa_pkg::OFF_STATUS, 8'h80, 8'h80);
        wr(isa_pkg::OFF_TX_BUF, 8'hc3);
        rd(isa_pkg::OFF_STATUS, 8'hc0, 8'h00);
        m.byte_x(8'hff, q);
        check(10'(q), 10'h0c3);
        m.ack9(ack);
        m.stop();
        rd(isa_pkg::OFF_STATUS, 8'hc0, 8'hc0);
        wr(isa_pkg::OFF_TX_BUF, 8'hff);
        rd(isa_pkg::OFF_STATUS, 8'hc0, 8'h00);
        wr(isa_pkg::OFF_SLV_ADDR, 8'h55);
        wr(isa_pkg::OFF_CTRL, 8'h01);
        rd(isa_pkg::OFF_STATUS, 8'h80, 8'h80);
        m.byte_x(8'h96, q);
        rd(isa_pkg::OFF_STATUS, 8'he0, 8'he0);
        rd(isa_pkg::OFF_RX_BUF, 8'hff, 8'h96);
        rd(isa_pkg::OFF_STATUS, 8'h20, 8'h00);
        give_verdict();
    end
endmodule
bind isa_top isa_assertions chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sda_o);
